/* scls_pkg.sv */
// package for the smart card line status block
// assumes an apb slave with byte-wide registers in the low data bits
package scls_pkg;
    // register indices; each register is one aligned word, its byte address is four times the index
    localparam logic [11:0] IDX_MON         = 12'h004;
    localparam logic [11:0] IDX_LSR         = 12'h005;
    localparam logic [11:0] IDX_FCR         = 12'h00c;
    localparam logic [11:0] IDX_CTRL        = 12'h010;
    localparam logic [11:0] ADDR_MON        = {IDX_MON[9:0], 2'b00};
    localparam logic [11:0] ADDR_LSR        = {IDX_LSR[9:0], 2'b00};
    localparam logic [11:0] ADDR_FCR        = {IDX_FCR[9:0], 2'b00};
    localparam logic [11:0] ADDR_CTRL       = {IDX_CTRL[9:0], 2'b00};
    localparam int          MON_TXFULL      = 7;
    localparam int          MON_PRESENT     = 5;
    localparam int          MON_REMOVED     = 4;
    localparam int          MON_THRESH      = 3;
    localparam int          MON_RST         = 2;
    localparam int          MON_IO          = 1;
    localparam int          MON_REPEAT      = 0;
    localparam int          LSR_PHASE       = 7;
    localparam int          LSR_TXDONE      = 6;
    localparam int          LSR_GUARD       = 5;
    localparam int          LSR_UNDER       = 4;
    localparam int          LSR_FRAME       = 3;
    localparam int          LSR_PARITY      = 2;
    localparam int          LSR_OVER        = 1;
    localparam int          LSR_READY       = 0;
    localparam int          FCR_RXEN        = 0;
    localparam int          FCR_TXEN        = 1;
    localparam int          CTRL_APD        = 0;
    localparam int          CTRL_T0         = 1;
    localparam int          CTRL_ATR        = 2;
    localparam logic [7:0]  LSR_RESET       = 8'h40;
    localparam logic [7:0]  FCR_RESET       = 8'h03;
    localparam logic [7:0]  CTRL_RESET      = 8'h00;
    localparam int          DEBOUNCE_NS     = 1000;
    localparam int          CLK_NS          = 8;
    localparam int          DEBOUNCE_CYC    = (DEBOUNCE_NS + CLK_NS - 1) / CLK_NS;
    localparam logic [7:0]  DEBOUNCE_CNT    = 8'(DEBOUNCE_CYC);

    typedef struct packed {
        logic tx_start;
        logic tx_last_done;
        logic guard_fail;
        logic rx_frame_err;
        logic rx_parity_err;
        logic tx_parity_err;
        logic rx_overrun;
        logic char_repeat;
        logic fifo_read_empty;
    } scls_evt_t;

    typedef struct packed {
        logic tx_full;
        logic rx_nonempty;
        logic thresh_req;
    } scls_fifo_t;

    typedef struct packed {
        logic [1:0] sync;
        logic       stable;
        logic [7:0] cnt;
        logic [7:0] mon;
        logic [7:0] lsr;
        logic [7:0] fifo_control_reg;
        logic [7:0] ctrl;
        logic [1:0] rst_sync;
        logic [1:0] io_sync;
        logic       deact;
        logic [7:0] rdata;
    } scls_state_t;
endpackage : scls_pkg

/* scls_line_status.sv */
// smart card line status and interface monitor registers
// assumes apb master on core_clk; card pins are asynchronous and synchronised here
`timescale 1ns/1ps
module scls_line_status (
    input  wire logic              core_clk,
    input  wire logic              rst_n,
    input  wire logic              psel,
    input  wire logic              penable,
    input  wire logic              pwrite,
    input  wire logic [11:0]       paddr,
    input  wire logic [31:0]       pwdata,
    input  wire logic [3:0]        pstrb,
    output logic                   pready,
    output logic      [31:0]       prdata,
    output logic                   pslverr,
    input  wire logic              card_present_pin,
    input  wire logic              card_reset_pin,
    input  wire logic              card_data_pin,
    input  wire scls_pkg::scls_evt_t  evt,
    input  wire scls_pkg::scls_fifo_t fifo,
    output logic                   fifo_read_ok,
    output logic                   rx_fifo_enable,
    output logic                   tx_fifo_enable,
    output logic                   icr_force_default,
    output logic                   card_deactivate
);
    scls_pkg::scls_state_t q, d;
    logic acc, wr, rd, hit_mon, hit_lsr, hit_fcr, hit_ctrl, present_now, t0_like;

    // ----------------------------------------
    // apb decode
    // ----------------------------------------
    assign acc      = psel & penable;
    assign wr       = acc & pwrite & pstrb[0];
    assign rd       = acc & ~pwrite;
    assign hit_mon  = paddr == scls_pkg::ADDR_MON;
    assign hit_lsr  = paddr == scls_pkg::ADDR_LSR;
    assign hit_fcr  = paddr == scls_pkg::ADDR_FCR;
    assign hit_ctrl = paddr == scls_pkg::ADDR_CTRL;
    assign pready   = 1'b1;
    assign pslverr  = acc & ~(hit_mon | hit_lsr | hit_fcr | hit_ctrl);
    assign prdata   = {24'h000000, q.rdata};
    assign t0_like  = q.ctrl[scls_pkg::CTRL_T0] | q.ctrl[scls_pkg::CTRL_ATR];

    // ----------------------------------------
    // next state
    // ----------------------------------------
    always_comb begin
        d = q;
        // ----------------------------------------
        // two-stage synchronisers, then a stability counter
        // ----------------------------------------
        d.sync     = {q.sync[0], card_present_pin};
        d.rst_sync = {q.rst_sync[0], card_reset_pin};
        d.io_sync  = {q.io_sync[0], card_data_pin};
        present_now = q.sync[1];
        if (present_now == q.stable) begin
            d.cnt = 8'h00;
        end else if (q.cnt == scls_pkg::DEBOUNCE_CNT - 8'h01) begin
            d.cnt    = 8'h00;
            d.stable = present_now;
        end else begin
            d.cnt = q.cnt + 8'h01;
        end

        // ----------------------------------------
        // monitor: live bits
        // ----------------------------------------
        d.mon[scls_pkg::MON_TXFULL]  = fifo.tx_full;
        d.mon[6]                     = 1'b0;
        d.mon[scls_pkg::MON_PRESENT] = q.sync[1];
        d.mon[scls_pkg::MON_THRESH]  = fifo.thresh_req;
        d.mon[scls_pkg::MON_RST]     = q.rst_sync[1];
        d.mon[scls_pkg::MON_IO]      = q.io_sync[1];
        // software clears first, hardware sets win
        if (wr && hit_mon) begin
            if (pwdata[scls_pkg::MON_REMOVED] && !q.stable) begin
                d.mon[scls_pkg::MON_REMOVED] = 1'b0;
            end
            if (pwdata[scls_pkg::MON_REPEAT]) begin
                d.mon[scls_pkg::MON_REPEAT] = 1'b0;
            end
        end
        if (q.stable && !d.stable) begin
            d.mon[scls_pkg::MON_REMOVED] = 1'b1;
        end
        if (q.stable) begin
            d.mon[scls_pkg::MON_REMOVED] = q.mon[scls_pkg::MON_REMOVED];
            if (!d.stable) begin
                d.mon[scls_pkg::MON_REMOVED] = 1'b1;
            end
        end
        if (evt.char_repeat && t0_like) begin
            d.mon[scls_pkg::MON_REPEAT] = 1'b1;
        end

        // ----------------------------------------
        // line status: read clears all but data ready
        // ----------------------------------------
        if (rd && hit_lsr) begin
            d.lsr[7:1] = 7'h00;
        end
        if (evt.tx_start) begin
            d.lsr[scls_pkg::LSR_TXDONE] = 1'b0;
        end else if (evt.tx_last_done) begin
            d.lsr[scls_pkg::LSR_TXDONE] = 1'b1;
        end
        if (evt.guard_fail) begin
            d.lsr[scls_pkg::LSR_GUARD] = 1'b1;
        end
        if (evt.fifo_read_empty) begin
            d.lsr[scls_pkg::LSR_UNDER] = 1'b1;
        end
        if (evt.rx_frame_err) begin
            d.lsr[scls_pkg::LSR_FRAME] = 1'b1;
        end
        if (evt.rx_parity_err || evt.tx_parity_err) begin
            d.lsr[scls_pkg::LSR_PARITY] = 1'b1;
            d.lsr[scls_pkg::LSR_PHASE]  = evt.rx_parity_err;
        end
        if (evt.rx_overrun) begin
            d.lsr[scls_pkg::LSR_OVER] = 1'b1;
        end
        d.lsr[scls_pkg::LSR_READY] = fifo.rx_nonempty;

        // ----------------------------------------
        // fifo enables: software writes, error events other than guard failure clear
        // ----------------------------------------
        if (wr && hit_fcr) begin
            d.fifo_control_reg = {6'h00, pwdata[1:0]};
        end
        if (evt.fifo_read_empty || evt.rx_frame_err || evt.rx_parity_err || evt.rx_overrun) begin
            d.fifo_control_reg[scls_pkg::FCR_RXEN] = 1'b0;
        end
        if (evt.tx_parity_err) begin
            d.fifo_control_reg[scls_pkg::FCR_TXEN] = 1'b0;
        end
        if (wr && hit_ctrl) begin
            d.ctrl = {5'h00, pwdata[2:0]};
        end

        // ----------------------------------------
        // deactivation pulse on parity error in t0 with auto enable
        // ----------------------------------------
        d.deact = (evt.rx_parity_err | evt.tx_parity_err)
                  & q.ctrl[scls_pkg::CTRL_APD] & q.ctrl[scls_pkg::CTRL_T0];

        // ----------------------------------------
        // read data register
        // ----------------------------------------
        d.rdata = 8'h00;
        if (psel && !penable && !pwrite) begin
            case (paddr)
                scls_pkg::ADDR_MON:  d.rdata = q.mon;
                scls_pkg::ADDR_LSR:  d.rdata = q.lsr;
                scls_pkg::ADDR_FCR:  d.rdata = q.fifo_control_reg;
                scls_pkg::ADDR_CTRL: d.rdata = q.ctrl;
                default:             d.rdata = 8'h00;
            endcase
        end else begin
            d.rdata = q.rdata;
        end
    end

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            q      <= '0;
            q.lsr  <= scls_pkg::LSR_RESET;
            q.fifo_control_reg  <= scls_pkg::FCR_RESET;
            q.ctrl <= scls_pkg::CTRL_RESET;
        end else begin
            q <= d;
        end
    end

    assign rx_fifo_enable    = q.fifo_control_reg[scls_pkg::FCR_RXEN];
    assign tx_fifo_enable    = q.fifo_control_reg[scls_pkg::FCR_TXEN];
    assign icr_force_default = q.mon[scls_pkg::MON_REMOVED];
    assign card_deactivate   = q.deact;
    assign fifo_read_ok      = fifo.rx_nonempty;

    // ----------------------------------------
    // checks
    // ----------------------------------------
    a_lsr_read_clear: assert property (@(posedge core_clk) disable iff (!rst_n)
        (rd && hit_lsr && !evt.rx_frame_err && !evt.rx_parity_err && !evt.tx_parity_err)
        |=> !q.lsr[scls_pkg::LSR_FRAME] && !q.lsr[scls_pkg::LSR_PARITY])
        else $error("line status read did not clear error flags");
    a_removed_hold: assert property (@(posedge core_clk) disable iff (!rst_n)
        (q.mon[scls_pkg::MON_REMOVED] && q.stable) |=> q.mon[scls_pkg::MON_REMOVED])
        else $error("card removed cleared while present");
    a_rx_disable: assert property (@(posedge core_clk) disable iff (!rst_n)
        evt.rx_overrun |=> !rx_fifo_enable && q.lsr[scls_pkg::LSR_OVER])
        else $error("overrun did not disable receive");
    a_under_flag: assert property (@(posedge core_clk) disable iff (!rst_n)
        evt.fifo_read_empty |=> q.lsr[scls_pkg::LSR_UNDER] && !rx_fifo_enable)
        else $error("underflow not flagged");
    a_tx_parity: assert property (@(posedge core_clk) disable iff (!rst_n)
        (evt.tx_parity_err && !evt.rx_parity_err) |=> !tx_fifo_enable && !q.lsr[scls_pkg::LSR_PHASE])
        else $error("transmit parity error handling wrong");
    a_deact_mode: assert property (@(posedge core_clk) disable iff (!rst_n)
        card_deactivate |-> $past(q.ctrl[scls_pkg::CTRL_T0]) && $past(q.ctrl[scls_pkg::CTRL_APD]))
        else $error("deactivation outside t0 auto mode");
    a_txdone_start: assert property (@(posedge core_clk) disable iff (!rst_n)
        evt.tx_start |=> !q.lsr[scls_pkg::LSR_TXDONE])
        else $error("transmit done not cleared at start");
    a_ready_live: assert property (@(posedge core_clk) disable iff (!rst_n)
        fifo.rx_nonempty |=> q.lsr[scls_pkg::LSR_READY])
        else $error("data ready not shown");

    // ----------------------------------------
    // checks: interface monitor
    // ----------------------------------------
    a_full_shown: assert property (@(posedge core_clk) disable iff (!rst_n)
        q.mon[scls_pkg::MON_TXFULL]
        == $past(fifo.tx_full))
        else $error("full bit does not follow the transmit queue");

    a_present_shown: assert property (@(posedge core_clk) disable iff (!rst_n)
        q.mon[scls_pkg::MON_PRESENT]
        == $past(q.sync[1]))
        else $error("present bit does not follow the pin");

    a_removed_set: assert property (@(posedge core_clk) disable iff (!rst_n)
        $fell(q.stable)
        |-> q.mon[scls_pkg::MON_REMOVED])
        else $error("card removal not flagged");

    a_removed_clear: assert property (@(posedge core_clk) disable iff (!rst_n)
        (wr && hit_mon && pwdata[scls_pkg::MON_REMOVED] && !q.stable)
        |=> !q.mon[scls_pkg::MON_REMOVED])
        else $error("card removed flag not cleared by write");

    a_force_default: assert property (@(posedge core_clk) disable iff (!rst_n)
        q.mon[scls_pkg::MON_REMOVED]
        |-> icr_force_default)
        else $error("interface control not held at default");

    a_thresh_shown: assert property (@(posedge core_clk) disable iff (!rst_n)
        q.mon[scls_pkg::MON_THRESH]
        == $past(fifo.thresh_req))
        else $error("threshold bit does not follow the request");

    a_pins_shown: assert property (@(posedge core_clk) disable iff (!rst_n)
        q.mon[scls_pkg::MON_RST] == $past(q.rst_sync[1])
        && q.mon[scls_pkg::MON_IO] == $past(q.io_sync[1]))
        else $error("reset or data pin level not shown");

    a_repeat_set: assert property (@(posedge core_clk) disable iff (!rst_n)
        (evt.char_repeat && t0_like)
        |=> q.mon[scls_pkg::MON_REPEAT])
        else $error("repeated character not flagged");

    a_repeat_clear: assert property (@(posedge core_clk) disable iff (!rst_n)
        (wr && hit_mon && pwdata[scls_pkg::MON_REPEAT] && !(evt.char_repeat && t0_like))
        |=> !q.mon[scls_pkg::MON_REPEAT])
        else $error("repeat flag not cleared by write");

    a_repeat_mode: assert property (@(posedge core_clk) disable iff (!rst_n)
        (!q.mon[scls_pkg::MON_REPEAT] && !(evt.char_repeat && t0_like))
        |=> !q.mon[scls_pkg::MON_REPEAT])
        else $error("repeat flag set outside t0 or atr");

    // ----------------------------------------
    // checks: line status and fifo enables
    // ----------------------------------------
    a_phase_rx: assert property (@(posedge core_clk) disable iff (!rst_n)
        evt.rx_parity_err
        |=> q.lsr[scls_pkg::LSR_PHASE])
        else $error("receive parity phase not recorded");

    a_txdone_end: assert property (@(posedge core_clk) disable iff (!rst_n)
        (evt.tx_last_done && !evt.tx_start)
        |=> q.lsr[scls_pkg::LSR_TXDONE])
        else $error("transmit done not set after last character");

    a_guard_flag: assert property (@(posedge core_clk) disable iff (!rst_n)
        evt.guard_fail
        |=> q.lsr[scls_pkg::LSR_GUARD])
        else $error("guard time failure not flagged");

    a_frame_flag: assert property (@(posedge core_clk) disable iff (!rst_n)
        evt.rx_frame_err
        |=> q.lsr[scls_pkg::LSR_FRAME] && !rx_fifo_enable)
        else $error("framing error handling wrong");

    a_rx_parity: assert property (@(posedge core_clk) disable iff (!rst_n)
        evt.rx_parity_err
        |=> q.lsr[scls_pkg::LSR_PARITY] && !rx_fifo_enable)
        else $error("receive parity error handling wrong");

    a_over_source: assert property (@(posedge core_clk) disable iff (!rst_n)
        (!evt.rx_overrun && !q.lsr[scls_pkg::LSR_OVER])
        |=> !q.lsr[scls_pkg::LSR_OVER])
        else $error("overrun set without a receive overrun");

    a_ready_clear: assert property (@(posedge core_clk) disable iff (!rst_n)
        !fifo.rx_nonempty
        |=> !q.lsr[scls_pkg::LSR_READY])
        else $error("data ready shown with no received data");

    a_read_clear_all: assert property (@(posedge core_clk) disable iff (!rst_n)
        (rd && hit_lsr && evt == '0)
        |=> q.lsr[7:1] == 7'h00)
        else $error("line status read left bits set");

    a_flags_sticky: assert property (@(posedge core_clk) disable iff (!rst_n)
        (!(rd && hit_lsr) && evt == '0)
        |=> q.lsr[7:1] == $past(q.lsr[7:1]))
        else $error("line status bits changed without read or event");

    // ----------------------------------------
    // checks: debounce and deactivation
    // ----------------------------------------
    a_auto_deact: assert property (@(posedge core_clk) disable iff (!rst_n)
        ((evt.rx_parity_err || evt.tx_parity_err) && q.ctrl[scls_pkg::CTRL_APD] && q.ctrl[scls_pkg::CTRL_T0])
        |=> card_deactivate)
        else $error("parity error did not deactivate the card");

    a_deact_cause: assert property (@(posedge core_clk) disable iff (!rst_n)
        !(evt.rx_parity_err || evt.tx_parity_err)
        |=> !card_deactivate)
        else $error("deactivation without parity error");

    a_deact_apd: assert property (@(posedge core_clk) disable iff (!rst_n)
        !q.ctrl[scls_pkg::CTRL_APD]
        |=> !card_deactivate)
        else $error("deactivation with auto deactivate off");

    a_deact_t0: assert property (@(posedge core_clk) disable iff (!rst_n)
        !q.ctrl[scls_pkg::CTRL_T0]
        |=> !card_deactivate)
        else $error("deactivation outside t0 mode");

    a_debounce_hold: assert property (@(posedge core_clk) disable iff (!rst_n)
        (q.sync[1] == q.stable)
        |=> q.stable == $past(q.stable))
        else $error("debounced present changed without pin change");

    a_debounce_wait: assert property (@(posedge core_clk) disable iff (!rst_n)
        (q.cnt != scls_pkg::DEBOUNCE_CNT - 8'h01)
        |=> q.stable == $past(q.stable))
        else $error("debounced present changed before full count");

    a_debounce_count: assert property (@(posedge core_clk) disable iff (!rst_n)
        (q.sync[1] != q.stable && q.cnt != scls_pkg::DEBOUNCE_CNT - 8'h01)
        |=> q.cnt == $past(q.cnt) + 8'h01)
        else $error("debounce counter did not advance");

endmodule : scls_line_status

/* scls_card_model.sv */
// card side model: present switch and contact levels
// assumes the bench steers insertion and contact levels
`timescale 1ns/1ps
module scls_card_model (
    input  wire logic inserted,
    input  wire logic rst_lvl,
    input  wire logic io_lvl,
    output logic      card_present_pin,
    output logic      card_reset_pin,
    output logic      card_data_pin
);
    // high level means a card sits in the socket
    assign card_present_pin = inserted;
    assign card_reset_pin   = rst_lvl;
    assign card_data_pin    = io_lvl;
endmodule : scls_card_model

/* testbench.sv */
// bench for the line status block: apb tasks, event pulses, card model
// assumes zero wait apb slave and the card model beside it
`timescale 1ns/1ps
module testbench;
    logic                 core_clk, rst_n, psel, penable, pwrite;
    logic [11:0]          paddr;
    logic [31:0]          pwdata, prdata;
    logic [3:0]           pstrb;
    logic                 pready, pslverr, pp, rp, dp, ins, rl, il;
    scls_pkg::scls_evt_t  evt;
    scls_pkg::scls_fifo_t fifo;
    logic                 rok, rxen, txen, icrd, deact;
    int                   err_total, samples_checked, cyc, nd, d0, i;
    logic [8:0]           ev [7] = '{9'h080, 9'h040, 9'h001, 9'h020, 9'h010, 9'h008, 9'h004};
    logic [7:0]           lx [7] = '{8'h41, 8'h21, 8'h11, 8'h09, 8'h85, 8'h05, 8'h03};
    logic [1:0]           fx [7] = '{2'h3, 2'h3, 2'h2, 2'h2, 2'h2, 2'h1, 2'h2};
    scls_line_status uut (.core_clk(core_clk), .rst_n(rst_n), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .pready(pready),
        .prdata(prdata), .pslverr(pslverr), .card_present_pin(pp), .card_reset_pin(rp),
        .card_data_pin(dp), .evt(evt), .fifo(fifo), .fifo_read_ok(rok), .rx_fifo_enable(rxen),
        .tx_fifo_enable(txen), .icr_force_default(icrd), .card_deactivate(deact));
    scls_card_model card (.inserted(ins), .rst_lvl(rl), .io_lvl(il), .card_present_pin(pp),
        .card_reset_pin(rp), .card_data_pin(dp));
    // ----------------------------------------
    // tasks
    // ----------------------------------------
    task automatic chk(input logic [31:0] s, input logic [31:0] x, input string nm);
        samples_checked++;
        if (s !== x) begin
            err_total++;
            $display("ERROR %s expected %h seen %h", nm, x, s);
        end
    endtask : chk
    task automatic apb(input logic w, input logic [11:0] a, input logic [7:0] d,
                       output logic [31:0] r, output logic e);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= w;
        paddr   <= a;
        pwdata  <= {24'h0, d};
        @(posedge core_clk);
        penable <= 1'b1;
        do begin
            @(posedge core_clk);
        end while (pready !== 1'b1);
        r = prdata;
        e = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
        @(posedge core_clk);
    endtask : apb
    task automatic rd(input logic [11:0] a, input logic [7:0] x, input string nm);
        logic [31:0] r;
        logic        e;
        apb(1'b0, a, 8'h00, r, e);
        chk(r, {24'h0, x}, nm);
    endtask : rd
    task automatic wr(input logic [11:0] a, input logic [7:0] d);
        logic [31:0] r;
        logic        e;
        apb(1'b1, a, d, r, e);
    endtask : wr
    task automatic pulse(input logic [8:0] e);
        evt <= e;
        @(posedge core_clk);
        evt <= '0;
        repeat (3) @(posedge core_clk);
    endtask : pulse
    task automatic complete_run;
        if (err_total == 0 && samples_checked > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask : complete_run
    // ----------------------------------------
    // clock, timeout, pulse counter
    // ----------------------------------------
    initial begin
        core_clk = 1'b0;
        forever #4 core_clk = ~core_clk;
    end
    always @(posedge core_clk) begin
        cyc++;
        if (deact === 1'b1) nd++;
        if (cyc == 20000) begin
            err_total++;
            complete_run;
        end
    end
    // ----------------------------------------
    // main sequence
    // ----------------------------------------
    initial begin
        logic [31:0] r;
        logic        e;
        rst_n = 0; psel = 0; penable = 0; pwrite = 0; paddr = '0; pwdata = '0; pstrb = 4'h1;
        evt = '0; fifo = '0; ins = 1; rl = 1; il = 1;
        repeat (16) @(posedge core_clk);
        rst_n <= 1'b1;
        repeat (4) @(posedge core_clk);
        rd(scls_pkg::ADDR_LSR, scls_pkg::LSR_RESET, "lsr reset");
        rd(scls_pkg::ADDR_MON, 8'h26, "mon pins");
        rl <= 1'b0; il <= 1'b0; fifo <= 3'b101;
        repeat (4) @(posedge core_clk);
        rd(scls_pkg::ADDR_MON, 8'ha8, "mon full thresh");
        wr(scls_pkg::ADDR_CTRL, 8'h02);
        pulse(9'h002);
        rd(scls_pkg::ADDR_MON, 8'ha9, "mon repeat");
        wr(scls_pkg::ADDR_MON, 8'h01);
        rd(scls_pkg::ADDR_MON, 8'ha8, "mon repeat clr");
        fifo <= 3'b010;
        for (i = 0; i < 7; i++) begin
            wr(scls_pkg::ADDR_FCR, 8'h03);
            pulse(ev[i]);
            chk({txen, rxen}, fx[i], "fifo enables");
            rd(scls_pkg::ADDR_LSR, lx[i], "lsr event");
            rd(scls_pkg::ADDR_LSR, 8'h01, "lsr after read");
        end
        fifo <= 3'b110;
        pulse(9'h080);
        pulse(9'h100);
        rd(scls_pkg::ADDR_LSR, 8'h01, "tx start clears done");
        fifo <= 3'b010;
        chk(rok, 1'b1, "read ok");
        wr(scls_pkg::ADDR_CTRL, 8'h01);
        d0 = nd;
        pulse(9'h010);
        chk(nd - d0, 0, "deact no t0");
        wr(scls_pkg::ADDR_CTRL, 8'h03);
        d0 = nd;
        pulse(9'h010);
        chk(nd - d0, 1, "deact t0");
        wr(scls_pkg::ADDR_CTRL, 8'h04);
        pulse(9'h002);
        rd(scls_pkg::ADDR_MON, 8'h21, "repeat atr");
        wr(scls_pkg::ADDR_MON, 8'h01);
        wr(scls_pkg::ADDR_CTRL, 8'h00);
        pulse(9'h002);
        rd(scls_pkg::ADDR_MON, 8'h20, "repeat other mode");
        apb(1'b0, 12'h020, 8'h00, r, e);
        chk(e, 1'b1, "unmapped");
        ins <= 1'b0;
        repeat (140) @(posedge core_clk);
        rd(scls_pkg::ADDR_MON, 8'h10, "mon removed");
        chk(icrd, 1'b1, "icr default");
        ins <= 1'b1;
        repeat (140) @(posedge core_clk);
        wr(scls_pkg::ADDR_MON, 8'h10);
        rd(scls_pkg::ADDR_MON, 8'h30, "clear ignored");
        ins <= 1'b0;
        repeat (140) @(posedge core_clk);
        wr(scls_pkg::ADDR_MON, 8'h10);
        rd(scls_pkg::ADDR_MON, 8'h00, "removed clr");
        chk(icrd, 1'b0, "icr released");
        complete_run;
    end
endmodule : testbench
